// ===== common/ebt_pkg.sv
package ebt_pkg;

	// Register offsets on the plain register port
	localparam logic [8:0] ADDR_TIMER_COUNT = 9'h001;
	localparam logic [8:0] ADDR_INT_CONTROL = 9'h00B;
	localparam logic [8:0] ADDR_OPTION_CFG  = 9'h081;
	localparam logic [8:0] ADDR_IRQ_STATUS  = 9'h190;
	localparam logic [8:0] ADDR_IRQ_CLEAR   = 9'h191;
	localparam logic [8:0] ADDR_IRQ_ENABLE  = 9'h192;

	// Reset values
	localparam logic [7:0] RST_TIMER_COUNT = 8'h00;
	localparam logic [7:0] RST_INT_CONTROL = 8'h00;
	localparam logic [7:0] RST_OPTION_CFG  = 8'hFF;
	localparam logic [1:0] RST_IRQ_ENABLE  = 2'h0;

	// Field positions
	localparam int OPT_COUNT_SOURCE_SELECT = 5;
	localparam int OPT_COUNT_EDGE_SELECT   = 4;
	localparam int OPT_SCALER_ASSIGN       = 3;
	localparam int OPT_SCALE_SELECT_HI     = 2;
	localparam int INT_OVERFLOW_IRQ_ENABLE = 5;
	localparam int INT_OVERFLOW_FLAG       = 2;
	localparam int IRQ_BIT_OVERFLOW        = 0;
	localparam int IRQ_BIT_EXT_EDGE        = 1;
	localparam int IRQ_BITS                = 2;

	// Phases of one instruction cycle, one clock each
	localparam logic [1:0] PHASE_TWO  = 2'h1;
	localparam logic [1:0] PHASE_FOUR = 2'h3;

	// Instruction cycles of hold-off after a count write
	localparam logic [1:0] WRITE_HOLDOFF = 2'h2;

	localparam logic [7:0] COUNT_ALL_ONES = 8'hFF;

endpackage

// ===== verilog/ebt_prescaler.sv
`timescale 1ns/10ps
`default_nettype none

module ebt_prescaler
	import ebt_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       tick_i,
	input  wire logic       clear_i,
	input  wire logic       for_timer_i,
	input  wire logic [2:0] scale_select_i,
	// Divided output
	output logic            out_o
);
	import ebt_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
	} ebt_pre_s;

	ebt_pre_s   s_q;
	ebt_pre_s   s_d;
	logic [3:0] shift;
	logic [7:0] mask;

	always_comb begin
		s_d = s_q;
		// Timer ratios start at 1:2, watchdog ratios at 1:1
		shift = {1'b0, scale_select_i} + {3'h0, for_timer_i};
		mask = 8'(({1'b0, 8'h01} << shift) - 9'h001);
		out_o = tick_i && ((s_q.cnt & mask) == mask);
		if (clear_i) begin
			s_d.cnt = 8'h00;
		end else if (tick_i) begin
			s_d.cnt = s_q.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule

`default_nettype wire

// ===== verilog/ebt_timer.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module ebt_timer
	import ebt_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// Register port
	input  wire logic [8:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// Core status
	input  wire logic       sleep_i,
	input  wire logic       watchdog_clear_instr_i,
	// Watchdog side of the shared prescaler
	input  wire logic       watchdog_timer_tick_i,
	output logic            watchdog_timer_post_o,
	// External count pin
	input  wire logic       ext_count_input_i,
	// Interrupts
	output logic            overflow_irq_o,
	output logic            irq_o
);
	import ebt_pkg::*;

	typedef struct packed {
		logic [1:0]          phase;
		logic                ext_s1;
		logic                ext_s2;
		logic                ext_prev;
		logic                pend;
		logic                samp;
		logic [1:0]          hold;
		logic [7:0]          count;
		logic [7:0]          int_ctl;
		logic [7:0]          option;
		logic [IRQ_BITS-1:0] irq_sts;
		logic [IRQ_BITS-1:0] irq_en;
		logic [7:0]          rdata;
		logic                wdt_post;
	} ebt_state_s;

	ebt_state_s s_q;
	ebt_state_s s_d;

	logic       wr_count;
	logic       wr_intctl;
	logic       wr_option;
	logic       wr_irqclr;
	logic       wr_irqen;
	logic       at_two;
	logic       at_four;
	logic       use_ext;
	logic       fall_sel;
	logic       for_timer;
	logic [2:0] scale;
	logic       ext_edge;
	logic       src_tick;
	logic       pre_tick;
	logic       pre_clear;
	logic       pre_out;
	logic       timer_out;
	logic       inc;
	logic       wrap;
	logic [IRQ_BITS-1:0] ev;

	assign wr_count  = reg_wr_i && (reg_addr_i == ADDR_TIMER_COUNT);
	assign wr_intctl = reg_wr_i && (reg_addr_i == ADDR_INT_CONTROL);
	assign wr_option = reg_wr_i && (reg_addr_i == ADDR_OPTION_CFG);
	assign wr_irqclr = reg_wr_i && (reg_addr_i == ADDR_IRQ_CLEAR);
	assign wr_irqen  = reg_wr_i && (reg_addr_i == ADDR_IRQ_ENABLE);

	assign at_two    = (s_q.phase == PHASE_TWO);
	assign at_four   = (s_q.phase == PHASE_FOUR);
	assign use_ext   = s_q.option[OPT_COUNT_SOURCE_SELECT];
	assign fall_sel  = s_q.option[OPT_COUNT_EDGE_SELECT];
	assign for_timer = !s_q.option[OPT_SCALER_ASSIGN];
	assign scale     = s_q.option[OPT_SCALE_SELECT_HI:0];

	// Edge taken from the second synchroniser stage only
	assign ext_edge = fall_sel ? (s_q.ext_prev && !s_q.ext_s2)
	                           : (!s_q.ext_prev && s_q.ext_s2);

	// Timer source: one tick per instruction cycle or one per edge
	assign src_tick = use_ext ? ext_edge : at_four;

	// Assignment is read live, so it may change on the fly
	assign pre_tick = for_timer ? (src_tick && !sleep_i)
	                            : watchdog_timer_tick_i;

	assign pre_clear = (for_timer && wr_count) ||
	                   (!for_timer && watchdog_clear_instr_i);

	ebt_prescaler u_prescaler (
		.clk_sys_i      (clk_sys_i),
		.rst_i          (rst_i),
		.tick_i         (pre_tick),
		.clear_i        (pre_clear),
		.for_timer_i    (for_timer),
		.scale_select_i (scale),
		.out_o          (pre_out)
	);

	// Prescaler bypassed when it serves the watchdog; sleep gates both
	// paths so an edge seen in sleep is not counted after wake-up
	assign timer_out = for_timer ? pre_out
	                             : (src_tick && !sleep_i);

	// External path lands via the phase-two/phase-four sampler
	assign inc = !sleep_i && (s_q.hold == 2'h0) && !wr_count &&
	             (use_ext ? (at_four && s_q.samp) : timer_out);

	assign wrap = inc && (s_q.count == COUNT_ALL_ONES);

	always_comb begin
		ev = '0;
		ev[IRQ_BIT_OVERFLOW] = wrap &&
		                       s_q.int_ctl[INT_OVERFLOW_IRQ_ENABLE];
		ev[IRQ_BIT_EXT_EDGE] = ext_edge;
	end

	always_comb begin
		s_d = s_q;
		s_d.phase = s_q.phase + 2'h1;

		// Two-stage pin synchroniser
		s_d.ext_s1   = ext_count_input_i;
		s_d.ext_s2   = s_q.ext_s1;
		s_d.ext_prev = s_q.ext_s2;

		// Output pulse held until the next phase-two sample
		if (use_ext && timer_out) begin
			s_d.pend = 1'b1;
		end
		if (at_two) begin
			s_d.samp = s_q.pend || (use_ext && timer_out);
			s_d.pend = 1'b0;
		end
		if (at_four) begin
			s_d.samp = 1'b0;
		end

		// Hold-off counts whole instruction cycles
		if (at_four && s_q.hold != 2'h0) begin
			s_d.hold = s_q.hold - 2'h1;
		end

		if (wr_count) begin
			s_d.count = reg_wdata_i;
			s_d.hold  = WRITE_HOLDOFF;
			s_d.pend  = 1'b0;
			s_d.samp  = 1'b0;
		end else if (inc) begin
			s_d.count = s_q.count + 8'h01;
		end

		if (wr_intctl) begin
			s_d.int_ctl = reg_wdata_i;
		end
		// Hardware set wins over a same-cycle software clear
		if (wrap) begin
			s_d.int_ctl[INT_OVERFLOW_FLAG] = 1'b1;
		end

		if (wr_option) begin
			s_d.option = reg_wdata_i;
		end

		if (wr_irqen) begin
			s_d.irq_en = reg_wdata_i[IRQ_BITS-1:0];
		end
		if (wr_irqclr) begin
			s_d.irq_sts = s_q.irq_sts & ~reg_wdata_i[IRQ_BITS-1:0];
		end
		s_d.irq_sts = s_d.irq_sts | ev;

		s_d.wdt_post = !for_timer && pre_out;

		// Unmapped and write-only addresses read as zero
		s_d.rdata = 8'h00;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				ADDR_TIMER_COUNT: s_d.rdata = s_q.count;
				ADDR_INT_CONTROL: s_d.rdata = s_q.int_ctl;
				ADDR_OPTION_CFG:  s_d.rdata = s_q.option;
				ADDR_IRQ_STATUS:  s_d.rdata = {6'h00, s_q.irq_sts};
				ADDR_IRQ_ENABLE:  s_d.rdata = {6'h00, s_q.irq_en};
				default:          s_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_q         <= '0;
			s_q.count   <= RST_TIMER_COUNT;
			s_q.int_ctl <= RST_INT_CONTROL;
			s_q.option  <= RST_OPTION_CFG;
			s_q.irq_en  <= RST_IRQ_ENABLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_o           = s_q.rdata;
	assign watchdog_timer_post_o = s_q.wdt_post;
	assign overflow_irq_o = s_q.int_ctl[INT_OVERFLOW_FLAG] &&
	                        s_q.int_ctl[INT_OVERFLOW_IRQ_ENABLE];
	assign irq_o = |(s_q.irq_sts & s_q.irq_en);

endmodule

`default_nettype wire

// ===== bench/ebt_timer_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ebt_timer_checker
	import ebt_pkg::*;
(
	input wire logic       clk_sys_i,
	input wire logic       rst_i,
	input wire logic [8:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       sleep_i,
	input wire logic       watchdog_clear_instr_i,
	input wire logic       watchdog_timer_tick_i,
	input wire logic       watchdog_timer_post_o,
	input wire logic       overflow_irq_o,
	input wire logic       irq_o
);
	import ebt_pkg::*;
	logic [7:0] opt_q;
	logic [1:0] en_q;
	wire w_int = reg_wr_i && reg_addr_i == ADDR_INT_CONTROL;
	wire wd = opt_q[3];
	// Shadow copies, since the checker cannot see inside
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			opt_q <= RST_OPTION_CFG;
			en_q <= RST_IRQ_ENABLE;
		end else if (reg_wr_i && reg_addr_i == ADDR_OPTION_CFG) begin
			opt_q <= reg_wdata_i;
		end else if (reg_wr_i && reg_addr_i == ADDR_IRQ_ENABLE) begin
			en_q <= reg_wdata_i[1:0];
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	property p_opt_rd; reg_rd_i && reg_addr_i == ADDR_OPTION_CFG
		|=> reg_rdata_o == opt_q; endproperty
	a_opt_rd: assert property (p_opt_rd) else $error("option read");
	property p_mask; w_int && !reg_wdata_i[5] |=> !overflow_irq_o; endproperty
	a_mask: assert property (p_mask) else $error("not masked");
	property p_unmask; w_int && reg_wdata_i[5] && reg_wdata_i[2]
		|=> overflow_irq_o; endproperty
	a_unmask: assert property (p_unmask) else $error("overflow lost");
	property p_irq_off; en_q == 2'h0 |-> !irq_o; endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq leak");
	property p_sleep; sleep_i && $past(sleep_i) && !$past(reg_wr_i)
		|-> !$rose(overflow_irq_o); endproperty
	a_sleep: assert property (p_sleep) else $error("wrap in sleep");
	property p_post_off; !wd && !$past(wd) |-> !watchdog_timer_post_o; endproperty
	a_post_off: assert property (p_post_off) else $error("post leak");
	property p_div1; wd && opt_q[2:0] == 3'h0 && watchdog_timer_tick_i
		|=> watchdog_timer_post_o; endproperty
	a_div1: assert property (p_div1) else $error("post 1:1");
	property p_wdclr; wd && opt_q[2:0] == 3'h1 && watchdog_clear_instr_i
		##1 watchdog_timer_tick_i |=> !watchdog_timer_post_o; endproperty
	a_wdclr: assert property (p_wdclr) else $error("clear ignored");
endmodule
bind ebt_timer ebt_timer_checker u_ebt_timer_checker (.clk_sys_i, .rst_i,
	.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sleep_i,
	.watchdog_clear_instr_i, .watchdog_timer_tick_i, .watchdog_timer_post_o,
	.overflow_irq_o, .irq_o);
`default_nettype wire

// ===== bench/ebt_pulse_src.sv
`timescale 1ns/10ps
`default_nettype none
module ebt_pulse_src (
	input  wire logic clk_sys_i,
	input  wire logic go_i,
	output logic      pin_o
);
	initial pin_o = 1'b0;
	// Ten clocks high, well past the sampling minimum
	always @(posedge clk_sys_i) begin
		if (go_i) begin
			pin_o <= 1'b1;
			repeat (10) @(posedge clk_sys_i);
			pin_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== bench/ebt_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ebt_timer_tb;
	import ebt_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [8:0] addr = 9'h000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0, rd = 1'b0, slp = 1'b0, wclr = 1'b0, tick = 1'b0;
	logic go = 1'b0, pin, post, ovf, irq;
	logic [7:0] rdata, v, a;
	int fail_count = 0, num_checks = 0, cyc = 0, posts = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	ebt_timer u_ebt_timer (.clk_sys_i, .rst_i, .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.sleep_i(slp), .watchdog_clear_instr_i(wclr),
		.watchdog_timer_tick_i(tick), .watchdog_timer_post_o(post),
		.ext_count_input_i(pin), .overflow_irq_o(ovf), .irq_o(irq));
	ebt_pulse_src u_ebt_pulse_src (.clk_sys_i, .go_i(go), .pin_o(pin));
	always @(posedge clk_sys_i) begin
		posts += post;
		cyc++;
		if (cyc == 5000) begin
			$display("MISMATCH timeout exp done got %0d cycles", cyc);
			fail_count++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [7:0] e, s);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wr_reg(input logic [8:0] ad, input logic [7:0] d);
		addr <= ad;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
		// Idle edge so a following write never re-raises the strobe at once
		@(posedge clk_sys_i);
	endtask
	task automatic wd_clear;
		wclr <= 1'b1;
		@(posedge clk_sys_i);
		wclr <= 1'b0;
	endtask
	// Data stands only in the cycle after the read edge
	task automatic rd_reg(input logic [8:0] ad);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1 v = rdata;
		@(posedge clk_sys_i);
	endtask
	task automatic t_reset;
		logic [8:0] m [7] = '{ADDR_OPTION_CFG, ADDR_INT_CONTROL,
			ADDR_IRQ_STATUS, ADDR_IRQ_CLEAR, 9'h1FF, ADDR_TIMER_COUNT,
			ADDR_IRQ_ENABLE};
		foreach (m[i]) begin
			rd_reg(m[i]);
			chk("reset", i == 0 ? RST_OPTION_CFG : 8'h00, v);
		end
		$display("t_reset done");
	endtask
	// Reads 40 clocks apart: 8 counts after hold-off, then 10
	task automatic t_timer;
		wr_reg(ADDR_OPTION_CFG, 8'h08);
		wr_reg(ADDR_TIMER_COUNT, 8'hF8);
		rd_reg(ADDR_TIMER_COUNT);
		chk("hold", 8'hF8, v);
		repeat (38) @(posedge clk_sys_i);
		rd_reg(ADDR_TIMER_COUNT);
		chk("wrap", 8'h00, v);
		repeat (38) @(posedge clk_sys_i);
		rd_reg(ADDR_TIMER_COUNT);
		chk("rate", 8'h0A, v);
		rd_reg(ADDR_INT_CONTROL);
		chk("flag", 8'h04, v);
		chk("masked", 8'h00, {7'h00, ovf});
		wr_reg(ADDR_INT_CONTROL, 8'h24);
		chk("unmasked", 8'h01, {7'h00, ovf});
		wr_reg(ADDR_INT_CONTROL, 8'h00);
		chk("flag_clr", 8'h00, {7'h00, ovf});
		slp <= 1'b1;
		wr_reg(ADDR_TIMER_COUNT, 8'h55);
		repeat (80) @(posedge clk_sys_i);
		rd_reg(ADDR_TIMER_COUNT);
		chk("sleep", 8'h55, v);
		slp <= 1'b0;
		$display("t_timer done");
	endtask
	task automatic t_presc;
		wd_clear();
		for (int p = 0; p < 3; p++) begin
			wr_reg(ADDR_OPTION_CFG, 8'(p));
			repeat (40) @(posedge clk_sys_i);
			rd_reg(ADDR_TIMER_COUNT);
			a = v;
			repeat (158) @(posedge clk_sys_i);
			rd_reg(ADDR_TIMER_COUNT);
			chk("ratio", 8'(20 >> p), v - a);
		end
		$display("t_presc done");
	endtask
	task automatic pulses(input int n, input logic [7:0] opt, want);
		wr_reg(ADDR_OPTION_CFG, opt);
		wr_reg(ADDR_TIMER_COUNT, 8'h00);
		// Let the hold-off after the count write run out first
		repeat (12) @(posedge clk_sys_i);
		repeat (n) begin
			go <= 1'b1;
			@(posedge clk_sys_i);
			go <= 1'b0;
			repeat (24) @(posedge clk_sys_i);
		end
		rd_reg(ADDR_TIMER_COUNT);
		chk("edges", want, v);
	endtask
	task automatic t_ext;
		pulses(3, 8'h28, 8'h03);
		pulses(2, 8'h38, 8'h02);
		// Cleared 1:2 prescaler passes only the second of three edges
		pulses(3, 8'h20, 8'h01);
		wr_reg(ADDR_IRQ_ENABLE, 8'h02);
		rd_reg(ADDR_IRQ_STATUS);
		chk("status", 8'h02, v);
		chk("irq", 8'h01, {7'h00, irq});
		wr_reg(ADDR_IRQ_CLEAR, 8'h02);
		rd_reg(ADDR_IRQ_STATUS);
		chk("cleared", 8'h00, v);
		chk("irq_off", 8'h00, {7'h00, irq});
		$display("t_ext done");
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			tick <= 1'b1;
			@(posedge clk_sys_i);
			tick <= 1'b0;
			@(posedge clk_sys_i);
		end
		@(posedge clk_sys_i);
	endtask
	task automatic t_wdt;
		int p0;
		// Hand-over to the watchdog, with the extra step for a 1:1 ratio
		wd_clear();
		wr_reg(ADDR_TIMER_COUNT, 8'h00);
		wr_reg(ADDR_OPTION_CFG, 8'h2F);
		wd_clear();
		wr_reg(ADDR_OPTION_CFG, 8'h08);
		p0 = posts;
		ticks(3);
		chk("post1", 8'h03, 8'(posts - p0));
		wr_reg(ADDR_OPTION_CFG, 8'h09);
		// Count stands at 3 here; only a clear makes three ticks give one post
		wd_clear();
		p0 = posts;
		ticks(3);
		chk("post2", 8'h01, 8'(posts - p0));
		$display("t_wdt done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		t_reset();
		t_timer();
		t_presc();
		t_ext();
		t_wdt();
		wrap_up();
	end
endmodule
`default_nettype wire
